// file: logic/sbr_pkg.sv
// Package of constants and types for the single-port block memory tile
//
// Functional notes
// - Write data and address are captured in input registers before the array; here the array's own address and write registers act as them.
// - Array writes happen only on a rising clock edge.
// - Option inserts or bypasses a register on read data.
// - Option picks asynchronous or synchronous action of the port reset.
// - Option decides whether global set/reset also clears the block registers.
// - Port reset clears input and output registers, never the array.
// - With ECC on, two-bit status; 00 clean, bit 0 single error corrected.
// - With ECC on, bit 1 flags an uncorrectable double-bit error.
// - Block acts on clock edges only while clock enable is high, except for preload writes and synchronous resets.
// - Write enable at a qualified edge stores write_word at the address.
// - Three-bit chip select acts as top address bits when tiles cascade.
// - Each tile holds 18,432 bits arranged by width and depth.
// - Array may be preloaded from an image; required for ROM use.
// - Aspect ratios 16Kx1 to 512x36, address 14 down to 9 bits.
// - Write mode normal or write-through; write-through shows written data.
// - Chip-select decode value picks the activating pattern, default zero.
package sbr_pkg;
   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int TILE_BITS = 18432;
   localparam int ROW_WIDTH = 36;
   localparam int ROW_COUNT = TILE_BITS / ROW_WIDTH;
   localparam int ROW_AW = 9;
   localparam int ADDR_W = 14;
   localparam int DATA_W = 36;
   localparam int CS_W = 3;
   localparam int ECC_W = 8;
   localparam int CODE_W = ROW_WIDTH + ECC_W;

   // ****************************************************************
   // Configuration encodings and defaults
   // ****************************************************************
   typedef enum logic [2:0] {
      SBR_W1 = 3'h0,
      SBR_W2 = 3'h1,
      SBR_W4 = 3'h2,
      SBR_W9 = 3'h3,
      SBR_W18 = 3'h4,
      SBR_W36 = 3'h5
   } sbr_width_t;
   localparam logic [2:0] CS_DECODE_RST = 3'h0;
   localparam logic [1:0] ERR_NONE = 2'h0;
   localparam int ERR_SINGLE_BIT = 0;
   localparam int ERR_DOUBLE_BIT = 1;

   // Lane width for a given ratio
   function automatic int unsigned lane_width(input sbr_width_t w);
      case (w)
         SBR_W1: lane_width = 1;
         SBR_W2: lane_width = 2;
         SBR_W4: lane_width = 4;
         SBR_W9: lane_width = 9;
         SBR_W18: lane_width = 18;
         default: lane_width = 36;
      endcase
   endfunction : lane_width
endpackage : sbr_pkg

// file: logic/sbr_array.sv
// Storage array of one memory tile with registered read port
`timescale 1ns/1ns
module sbr_array (
   // Clock
   input wire logic clk,
   // Port
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [sbr_pkg::ROW_AW-1:0] addr,
   input wire logic [sbr_pkg::CODE_W-1:0] wr_row,
   input wire logic [sbr_pkg::CODE_W-1:0] wr_mask,
   output logic [sbr_pkg::CODE_W-1:0] rd_row
);
   logic [sbr_pkg::CODE_W-1:0] mem [0:sbr_pkg::ROW_COUNT-1];

   // ****************************************************************
   // Array; contents have no reset at all
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (wr_en) begin
         // Masked bits only; the rest of the row keeps its stored lanes
         mem[addr] <= (mem[addr] & ~wr_mask) | (wr_row & wr_mask);
      end
      if (rd_en) begin
         rd_row <= mem[addr];
      end
   end
endmodule : sbr_array

// file: logic/sbr_ecc.sv
// Hamming SECDED encoder and corrector for one 36-bit row
`timescale 1ns/1ns
module sbr_ecc (
   // Encode side
   input wire logic [sbr_pkg::ROW_WIDTH-1:0] enc_data,
   output logic [sbr_pkg::CODE_W-1:0] enc_row,
   // Decode side
   input wire logic [sbr_pkg::CODE_W-1:0] dec_row,
   output logic [sbr_pkg::ROW_WIDTH-1:0] dec_data,
   output logic [1:0] dec_err
);
   localparam int NPOS = 43; // Hamming positions 1..42 used

   // Spread data over non-power-of-two positions
   function automatic logic [NPOS-1:0] spread(input logic [sbr_pkg::ROW_WIDTH-1:0] d);
      logic [NPOS-1:0] v;
      int k;
      v = '0;
      k = 0;
      for (int p = 1; p < NPOS; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (k < sbr_pkg::ROW_WIDTH) v[p] = d[k];
            k++;
         end
      end
      spread = v;
   endfunction : spread

   // Syndrome of a position vector
   function automatic logic [6:0] syn(input logic [NPOS-1:0] v);
      logic [6:0] s;
      s = '0;
      for (int p = 1; p < NPOS; p++) begin
         if (v[p]) s = s ^ p[6:0];
      end
      syn = s;
   endfunction : syn

   logic [NPOS-1:0] ev;
   logic [NPOS-1:0] dv;
   logic [6:0] es;
   logic [6:0] ds;

   // Encode: check bits make the syndrome zero, last bit is overall parity
   always_comb begin
      ev = spread(enc_data);
      es = syn(ev);
      enc_row = {^{ev, es}, es, enc_data};
   end

   // Decode: correct a single flip, flag a double one
   always_comb begin
      dv = spread(dec_row[sbr_pkg::ROW_WIDTH-1:0]);
      ds = syn(dv) ^ dec_row[sbr_pkg::CODE_W-2:sbr_pkg::ROW_WIDTH];
      dec_data = dec_row[sbr_pkg::ROW_WIDTH-1:0];
      dec_err = sbr_pkg::ERR_NONE;
      if (ds != 7'h00 || ^dec_row) begin
         if (^dec_row) begin
            dec_err[sbr_pkg::ERR_SINGLE_BIT] = 1'b1;
            for (int p = 1, k = 0; p < NPOS; p++) begin
               if ((p & (p - 1)) != 0) begin
                  if (p[6:0] == ds && k < sbr_pkg::ROW_WIDTH) dec_data[k] = ~dec_data[k];
                  k++;
               end
            end
         end else begin
            dec_err[sbr_pkg::ERR_DOUBLE_BIT] = 1'b1;
         end
      end
   end
endmodule : sbr_ecc

// file: logic/sbr_tile.sv
// Single-port block memory tile with options, chip select and ECC status
`timescale 1ns/1ns
module sbr_tile #(
   parameter sbr_pkg::sbr_width_t WIDTH_MODE = sbr_pkg::SBR_W36,
   parameter bit OUT_REG = 1'b0,
   parameter bit RESET_SYNC = 1'b0,
   parameter bit GSR_ENABLE = 1'b1,
   parameter bit WRITE_THROUGH = 1'b0,
   parameter bit ECC_ENABLE = 1'b0,
   parameter logic [2:0] CS_DECODE = sbr_pkg::CS_DECODE_RST
) (
   // Clock and resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic port_rst,
   input wire logic global_set_reset,
   // User port
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [2:0] chip_sel,
   input wire logic [sbr_pkg::ADDR_W-1:0] addr,
   input wire logic [sbr_pkg::DATA_W-1:0] write_word,
   output logic [sbr_pkg::DATA_W-1:0] read_word,
   output logic [1:0] ecc_err,
   // Preload
   input wire logic init_en,
   input wire logic [sbr_pkg::ROW_AW-1:0] init_addr,
   input wire logic [sbr_pkg::ROW_WIDTH-1:0] init_row
);
   localparam int LW = sbr_pkg::lane_width(WIDTH_MODE);
   localparam int LPR = sbr_pkg::ROW_WIDTH / LW;
   localparam int SH = (WIDTH_MODE == sbr_pkg::SBR_W36) ? 0 : (WIDTH_MODE == sbr_pkg::SBR_W18) ? 1 :
                       (WIDTH_MODE == sbr_pkg::SBR_W9) ? 2 : (WIDTH_MODE == sbr_pkg::SBR_W4) ? 3 :
                       (WIDTH_MODE == sbr_pkg::SBR_W2) ? 4 : 5;
   // Check bits cover whole rows only, so narrow ratios run without ECC
   localparam bit ECC_ON = ECC_ENABLE && (LPR == 1);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic sel;
      logic we;
      logic [sbr_pkg::ADDR_W-1:0] addr;
      logic [sbr_pkg::DATA_W-1:0] din;
      logic hold_a;
      logic [sbr_pkg::DATA_W-1:0] q_a;
      logic [sbr_pkg::DATA_W-1:0] q_o;
      logic [1:0] e_a;
      logic [1:0] e_o;
   } sbr_state_t;

   sbr_state_t st;
   sbr_state_t next_st;
   sbr_state_t clr_st;

   logic reg_clear;
   logic port_sel;
   logic [sbr_pkg::CODE_W-1:0] arr_mask;
   logic arr_we;
   logic arr_re;
   logic [sbr_pkg::ROW_AW-1:0] row_addr;
   logic [sbr_pkg::ROW_WIDTH-1:0] merged;
   logic [sbr_pkg::CODE_W-1:0] enc_row;
   logic [sbr_pkg::CODE_W-1:0] rd_row;
   logic [sbr_pkg::ROW_WIDTH-1:0] dec_data;
   logic [1:0] dec_err;
   logic [sbr_pkg::ROW_WIDTH-1:0] lane_out;
   logic [sbr_pkg::DATA_W-1:0] arr_word;
   logic [1:0] arr_err;

   // Global set/reset only counts when enabled
   assign reg_clear = port_rst | sys_rst | (GSR_ENABLE & global_set_reset);

   // Row address and lane within it; the 36-bit mode needs no lane split
   function automatic logic [sbr_pkg::ROW_AW-1:0] row_of(input logic [sbr_pkg::ADDR_W-1:0] a);
      row_of = sbr_pkg::ROW_AW'(a >> SH);
   endfunction : row_of

   function automatic int unsigned lane_of(input logic [sbr_pkg::ADDR_W-1:0] a);
      lane_of = (LPR > 1) ? (int'(a) % (1 << SH)) % LPR : 0;
   endfunction : lane_of

   // ****************************************************************
   // Array access at the taking edge
   // ****************************************************************
   // The array's own address and write registers act as the input registers, so a write lands
   // at the edge that takes it and a read taken one edge later already sees it
   assign port_sel = (chip_sel == CS_DECODE);
   assign row_addr = init_en ? init_addr : row_of(next_st.addr);
   assign arr_we = init_en | (~reg_clear & clk_en & port_sel & wr_en);
   assign arr_re = ~init_en; // Preload leaves the row under read untouched

   // Write row and bit mask; the array keeps the other lanes, so narrow writes need no read first
   always_comb begin
      merged = init_en ? init_row : '0;
      arr_mask = '1;
      if (!init_en) begin
         if (!ECC_ON) arr_mask = '0;
         for (int i = 0; i < LPR; i++) begin
            if (i == lane_of(addr)) begin
               merged[i*LW +: LW] = write_word[LW-1:0];
               if (!ECC_ON) arr_mask[i*LW +: LW] = '1;
            end
         end
      end
   end

   sbr_ecc u_ecc (
      .enc_data(merged),
      .enc_row(enc_row),
      .dec_row(rd_row),
      .dec_data(dec_data),
      .dec_err(dec_err)
   );

   sbr_array u_array (
      .clk(clk),
      .wr_en(arr_we),
      .rd_en(arr_re),
      .addr(row_addr),
      .wr_row(ECC_ON ? enc_row : {{sbr_pkg::ECC_W{1'b0}}, merged}),
      .wr_mask(arr_mask),
      .rd_row(rd_row)
   );

   // Lane select of the row just read
   always_comb begin
      lane_out = ECC_ON ? dec_data : rd_row[sbr_pkg::ROW_WIDTH-1:0];
      arr_word = '0;
      for (int i = 0; i < LPR; i++) begin
         if (i == lane_of(st.addr)) arr_word[LW-1:0] = lane_out[i*LW +: LW];
      end
      arr_err = ECC_ON ? dec_err : sbr_pkg::ERR_NONE;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      clr_st = '0;
      next_st = st;
      if (clk_en) begin
         next_st.sel = port_sel;
         next_st.we = wr_en;
         next_st.addr = addr;
         next_st.din = write_word;
         // Array stage: the row read at the taking edge is latched into q_a one qualified edge later
         if (st.sel && st.we) begin
            if (WRITE_THROUGH) next_st.q_a = st.din;
            else next_st.q_a = st.q_a;
         end else if (st.sel) begin
            next_st.q_a = arr_word;
            next_st.e_a = arr_err;
         end
         next_st.q_o = st.q_a;
         next_st.e_o = st.e_a;
      end
      if (RESET_SYNC && reg_clear) next_st = clr_st;
   end

   // One register stage per variant; async variant clears without clock
   generate
      if (RESET_SYNC) begin : g_sync
         always_ff @(posedge clk) begin
            st <= next_st;
         end
      end else begin : g_async
         always_ff @(posedge clk or posedge reg_clear) begin
            if (reg_clear) st <= '0;
            else st <= next_st;
         end
      end
   endgenerate

   // ****************************************************************
   // Output selection, registered or bypassed
   // ****************************************************************
   assign read_word = OUT_REG ? st.q_o : st.q_a;
   assign ecc_err = OUT_REG ? st.e_o : st.e_a;
endmodule : sbr_tile

// file: tb/sbr_user.sv
// Fabric-side port driver for the tile
`timescale 1ns/1ns
module sbr_user (
   // Clock
   input wire logic clk,
   // Request
   output logic clk_en,
   output logic wr_en,
   output logic [2:0] chip_sel,
   output logic [sbr_pkg::ADDR_W-1:0] addr,
   output logic [sbr_pkg::DATA_W-1:0] write_word,
   // Answer
   input wire logic [sbr_pkg::DATA_W-1:0] read_word
);
   initial begin
      clk_en = 1'h0;
      wr_en = 1'h0;
      chip_sel = 3'h0;
      addr = 14'h0;
      write_word = 36'h0;
   end
   // One request per falling edge; q is what the last rising edge left
   task automatic op(input logic ce, we, input logic [2:0] cs, input logic [13:0] a, input logic [35:0] d,
         output logic [35:0] q);
      @(negedge clk);
      q = read_word;
      clk_en = ce;
      wr_en = we;
      chip_sel = cs;
      addr = a;
      write_word = we ? d : ~write_word; // Reads carry the complement of the previous word
   endtask : op
endmodule : sbr_user

// file: tb/sbr_tile_chk.sv
// Port timing checker for the tile
`timescale 1ns/1ns
module sbr_tile_chk #(
   parameter logic [2:0] CS_DECODE = 3'h0,
   parameter bit GSR_ENABLE = 1'b1,
   parameter bit ECC_ENABLE = 1'b0
) (
   // Clock and resets
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic port_rst,
   input wire logic global_set_reset,
   // Port
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [2:0] chip_sel,
   input wire logic [sbr_pkg::DATA_W-1:0] read_word,
   input wire logic [1:0] ecc_err
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic any_rst;
   // Resets may clear the output at any time, so hold checks allow them
   assign any_rst = port_rst | global_set_reset;
   chk_ecc_off: assert property (ECC_ENABLE || ecc_err == 2'h0) else $error("ecc status set");
   chk_ce_freeze: assert property (!any_rst && !clk_en |=> any_rst || $stable(read_word))
      else $error("output moved with clock enable low");
   chk_ce_pair: assert property ((!any_rst && !clk_en) [*2] |=> any_rst || read_word == $past(read_word, 2))
      else $error("output moved over idle pair");
   chk_rst_clear: assert property (port_rst |=> read_word == '0) else $error("port reset left data");
   chk_gsr_clear: assert property (GSR_ENABLE && global_set_reset |=> read_word == '0)
      else $error("global reset left data");
   chk_rst_zero: assert property ($fell(port_rst) |-> read_word == '0) else $error("data at reset release");
   chk_wr_hold: assert property (!any_rst && clk_en && wr_en && chip_sel == CS_DECODE ##1 !any_rst && clk_en
      |=> any_rst || $stable(read_word)) else $error("output changed on write");
   chk_unsel_hold: assert property (!any_rst && clk_en && chip_sel != CS_DECODE ##1 !any_rst && clk_en
      |=> any_rst || $stable(read_word)) else $error("unselected tile answered");
   cp_write: cover property (clk_en && wr_en && chip_sel == CS_DECODE);
   cp_idle: cover property (!clk_en ##1 clk_en);
   cp_rst: cover property ($rose(port_rst));
endmodule : sbr_tile_chk
bind sbr_tile sbr_tile_chk #(.CS_DECODE(CS_DECODE), .GSR_ENABLE(GSR_ENABLE), .ECC_ENABLE(ECC_ENABLE))
   u_chk (.clk(clk), .sys_rst(sys_rst), .port_rst(port_rst),
   .global_set_reset(global_set_reset), .clk_en(clk_en), .wr_en(wr_en), .chip_sel(chip_sel),
   .read_word(read_word), .ecc_err(ecc_err));

// file: tb/tb.sv
// Self-checking bench for the block memory tile
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
   logic clk = 1'h0;
   logic sys_rst = 1'h1;
   logic port_rst = 1'h0;
   logic global_set_reset = 1'h0;
   logic init_en = 1'h0;
   logic [8:0] init_addr = 9'h0;
   logic [35:0] init_row = 36'h0;
   logic clk_en, wr_en;
   logic [2:0] chip_sel;
   logic [sbr_pkg::ADDR_W-1:0] addr;
   logic [sbr_pkg::DATA_W-1:0] write_word, read_word, q;
   logic [1:0] ecc_err;
   logic [35:0] mem [0:511];
   logic [35:0] pipe [0:1];
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   always #25 clk = ~clk;
   sbr_tile u_sbr_tile (.clk(clk), .sys_rst(sys_rst), .port_rst(port_rst), .global_set_reset(global_set_reset),
      .clk_en(clk_en), .wr_en(wr_en), .chip_sel(chip_sel), .addr(addr), .write_word(write_word),
      .read_word(read_word), .ecc_err(ecc_err), .init_en(init_en), .init_addr(init_addr), .init_row(init_row));
   sbr_user u_sbr_user (.clk(clk), .clk_en(clk_en), .wr_en(wr_en), .chip_sel(chip_sel), .addr(addr),
      .write_word(write_word), .read_word(read_word));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // Unknown expectations (after reset, unwritten rows) are skipped
   task automatic step(input logic ce, we, input logic [13:0] a, input logic [35:0] d,
         input logic [2:0] cs = sbr_pkg::CS_DECODE_RST);
      logic [35:0] e;
      u_sbr_user.op(ce, we, cs, a, d, q);
      if (pipe[1] !== 36'hx) `CHK(q, pipe[1])
      `CHK(ecc_err, sbr_pkg::ERR_NONE)
      if (ce) begin
         e = (!we && cs == sbr_pkg::CS_DECODE_RST) ? mem[a[8:0]] : pipe[0];
         if (we && cs == sbr_pkg::CS_DECODE_RST) mem[a[8:0]] = d;
         pipe[1] = pipe[0];
         pipe[0] = e;
      end
   endtask : step
   task automatic wr(input logic [13:0] a, input logic [35:0] d);
      step(1'h1, 1'h1, a, d);
   endtask : wr
   task automatic rd(input logic [13:0] a);
      step(1'h1, 1'h0, a, 36'h0);
   endtask : rd
   task automatic t_rw();
      wr(14'h0000, 36'hF_FFFF_FFFF);
      wr(14'h01FF, 36'hA_5A5A_5A5A);
      rd(14'h0000);
      wr(14'h0000, 36'h1_2345_6789);
      rd(14'h0000);
      rd(14'h01FF);
      repeat (2) rd(14'h0000);
      $display("test rw done");
   endtask : t_rw
   task automatic t_ce();
      wr(14'h0010, 36'h0_0000_1111);
      rd(14'h0010);
      step(1'h0, 1'h1, 14'h0010, 36'h0_0000_2222);
      step(1'h0, 1'h0, 14'h0000, 36'h0);
      repeat (3) rd(14'h0010);
      $display("test ce done");
   endtask : t_ce
   task automatic t_cs();
      for (int s = 1; s < 8; s++) step(1'h1, 1'h1, 14'h0010, 36'h7_7777_7777, 3'(s));
      repeat (3) rd(14'h0010);
      $display("test cs done");
   endtask : t_cs
   task automatic t_rst();
      for (int k = 0; k < 2; k++) begin
         wr(14'h0020, 36'hC_0FFE_E000);
         rd(14'h0000);
         step(1'h0, 1'h0, 14'h0000, 36'h0);
         if (k == 0) port_rst = 1'h1;
         else global_set_reset = 1'h1;
         @(negedge clk);
         `CHK(read_word, 36'h0)
         port_rst = 1'h0;
         global_set_reset = 1'h0;
         pipe[0] = 36'hx;
         pipe[1] = 36'hx;
         repeat (3) rd(14'h0020);
      end
      $display("test reset done");
   endtask : t_rst
   task automatic t_init();
      step(1'h0, 1'h0, 14'h0000, 36'h0);
      init_en = 1'h1;
      init_addr = 9'h055;
      init_row = 36'h9_8765_4321;
      @(negedge clk);
      init_en = 1'h0;
      mem[9'h055] = init_row;
      repeat (2) rd(14'h0055);
      @(posedge clk);
      #1;
      `CHK(read_word, 36'h9_8765_4321)
      $display("test preload done");
   endtask : t_init
   // Cut a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      for (int i = 0; i < 512; i++) mem[i] = 36'hx;
      pipe[0] = 36'hx;
      pipe[1] = 36'hx;
      repeat (10) @(negedge clk);
      sys_rst = 1'h0;
      t_rw();
      t_ce();
      t_cs();
      t_rst();
      t_init();
      give_verdict();
   end
endmodule : tb
